/* hdl/pcd_discovery_status.sv */
// Channel 2 to 4 discovery status registers with command-code read port
`timescale 1ns/1ns
`include "pcd_consts.svh"
module pcd_discovery_status
  import pcd_pkg::*;
(
  input  wire logic           core_clk,
  input  wire logic           nrst,
  input  wire logic [2:0]     resultValid,
  input  wire pcd_nibble_type requestedPowerTier2,
  input  wire pcd_nibble_type requestedPowerTier3,
  input  wire pcd_nibble_type requestedPowerTier4,
  input  wire pcd_nibble_type signatureOutcome2,
  input  wire pcd_nibble_type signatureOutcome3,
  input  wire pcd_nibble_type signatureOutcome4,
  input  wire logic [2:0]     channelOff,
  input  wire logic           cmdRead,
  input  wire logic           cmdWrite,
  input  wire pcd_byte_type   cmdCode,
  input  wire pcd_byte_type   cmdWriteData,
  output pcd_byte_type        readData,
  output logic                readHit
);
  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rstSync1;
  logic rstN;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstSync1 <= 1'b0;
      rstN     <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstN     <= rstSync1;
    end
  end

  // ------------------------------------------------------------
  // Channel status bytes
  // ------------------------------------------------------------
  pcd_byte_type status2;
  pcd_byte_type status3;
  pcd_byte_type status4;

  pcd_channel_status u_ch2 (
    .clk                (core_clk),
    .rstN               (rstN),
    .resultValid        (resultValid[0]),
    .requestedPowerTier (requestedPowerTier2),
    .signatureOutcome   (signatureOutcome2),
    .channelOff         (channelOff[0]),
    .status             (status2)
  );
  pcd_channel_status u_ch3 (
    .clk                (core_clk),
    .rstN               (rstN),
    .resultValid        (resultValid[1]),
    .requestedPowerTier (requestedPowerTier3),
    .signatureOutcome   (signatureOutcome3),
    .channelOff         (channelOff[1]),
    .status             (status3)
  );
  pcd_channel_status u_ch4 (
    .clk                (core_clk),
    .rstN               (rstN),
    .resultValid        (resultValid[2]),
    .requestedPowerTier (requestedPowerTier4),
    .signatureOutcome   (signatureOutcome4),
    .channelOff         (channelOff[2]),
    .status             (status4)
  );

  // ------------------------------------------------------------
  // Read decode
  // ------------------------------------------------------------
  // channel two decode
  wire logic hit2 = (cmdCode == `PCD_CMD_CH2);
  wire logic hit3 = (cmdCode == `PCD_CMD_CH3);
  wire logic hit4 = (cmdCode == `PCD_CMD_CH4);
  wire logic anyHit = hit2 | hit3 | hit4;
  wire pcd_byte_type selData = hit2 ? status2 :
                               hit3 ? status3 :
                               hit4 ? status4 : 8'h00;
  // Writes are ignored and unmapped reads load 8'h00 with readHit low; cmdWrite/cmdWriteData never reach storage
  wire pcd_byte_type next_readData = cmdRead ? selData : readData;
  wire logic         next_readHit  = cmdRead & anyHit;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      readData <= 8'h00;
      readHit  <= 1'b0;
    end else if (!rstN) begin
      readData <= 8'h00;
      readHit  <= 1'b0;
    end else begin
      readData <= next_readData;
      readHit  <= next_readHit;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // read returns channel two
  read_ch2_a: assert property (@(posedge core_clk) disable iff (!rstN)
    (cmdRead && cmdCode == 8'h0d) |=> (readHit && readData == $past(status2)))
    else $error("channel two read mismatch");
  write_ignored_a: assert property (@(posedge core_clk) disable iff (!rstN)
    (cmdWrite && hit2 && !resultValid[0] && !channelOff[0]) |=> status2 == $past(status2))
    else $error("write changed channel two status");
  read_ch3_a: assert property (@(posedge core_clk) disable iff (!rstN)
    (cmdRead && cmdCode == 8'h0e) |=> (readHit && readData == $past(status3)))
    else $error("channel three read mismatch");
  read_ch4_a: assert property (@(posedge core_clk) disable iff (!rstN)
    (cmdRead && cmdCode == 8'h0f) |=> (readHit && readData == $past(status4)))
    else $error("channel four read mismatch");
  field_place_a: assert property (@(posedge core_clk) disable iff (!rstN)
    (resultValid[1] && !channelOff[1] && requestedPowerTier3 == 4'h1 && signatureOutcome3 == 4'h4)
    |=> status3 == 8'h14)
    else $error("fields misplaced");
  class5_8_a: assert property (@(posedge core_clk) disable iff (!rstN)
    (resultValid[2] && !channelOff[2] && requestedPowerTier4[3:2] == 2'b10) |=>
    status4[7:4] == $past(requestedPowerTier4))
    else $error("class 5-8 code altered");
  lim_mismatch_a: assert property (@(posedge core_clk) disable iff (!rstN)
    (resultValid[0] && !channelOff[0] && (requestedPowerTier2 == 4'hd || requestedPowerTier2 == 4'hf)) |=>
    status2[7:4] == $past(requestedPowerTier2))
    else $error("type-1 limited or mismatch code altered");
  unmapped_a: assert property (@(posedge core_clk) disable iff (!rstN)
    (cmdRead && !anyHit) |=> (!readHit && readData == 8'h00))
    else $error("unmapped code answered");
endmodule // pcd_discovery_status

/* hdl/pcd_consts.svh */
// Constants for the channel discovery status bank
`ifndef PCD_CONSTS_SVH
`define PCD_CONSTS_SVH
// ------------------------------------------------------------
// Command codes
// ------------------------------------------------------------
`define PCD_CMD_CH2        8'h0d
`define PCD_CMD_CH3        8'h0e
`define PCD_CMD_CH4        8'h0f
// ------------------------------------------------------------
// Field layout and reset
// ------------------------------------------------------------
`define PCD_TIER_MSB       7
`define PCD_TIER_LSB       4
`define PCD_SIG_MSB        3
`define PCD_SIG_LSB        0
`define PCD_STATUS_RESET   8'h00
// ------------------------------------------------------------
// Requested power tier codes
// ------------------------------------------------------------
`define PCD_TIER_UNKNOWN   4'h0
`define PCD_TIER_CLASS1    4'h1
`define PCD_TIER_RSVD      4'h5
`define PCD_TIER_CLASS0    4'h6
`define PCD_TIER_CLASS5    4'h8
`define PCD_TIER_CLASS6    4'h9
`define PCD_TIER_CLASS7    4'ha
`define PCD_TIER_CLASS8    4'hb
`define PCD_TIER_C4_T1     4'hd
`define PCD_TIER_MISMATCH  4'hf
// ------------------------------------------------------------
// Signature outcome codes
// ------------------------------------------------------------
`define PCD_SIG_UNKNOWN    4'h0
`define PCD_SIG_SHORT      4'h1
`define PCD_SIG_LOW        4'h3
`define PCD_SIG_VALID      4'h4
`define PCD_SIG_HIGH       4'h5
`endif

/* hdl/pcd_pkg.sv */
// Types for the channel discovery status bank
package pcd_pkg;
  typedef logic [3:0] pcd_nibble_type;
  typedef logic [7:0] pcd_byte_type;
endpackage

/* hdl/pcd_channel_status.sv */
// One channel's discovery status byte
`timescale 1ns/1ns
`include "pcd_consts.svh"
module pcd_channel_status
  import pcd_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           rstN,
  input  wire logic           resultValid,
  input  wire pcd_nibble_type requestedPowerTier,
  input  wire pcd_nibble_type signatureOutcome,
  input  wire logic           channelOff,
  output pcd_byte_type        status
);
  // ------------------------------------------------------------
  // Code mapping
  // ------------------------------------------------------------
  // tier code map
  wire pcd_nibble_type tierMapped = (requestedPowerTier == `PCD_TIER_RSVD) ? `PCD_TIER_CLASS0
                                                                              : requestedPowerTier;
  wire logic sigKnown = (signatureOutcome == `PCD_SIG_UNKNOWN) || (signatureOutcome == `PCD_SIG_SHORT) ||
                        (signatureOutcome == `PCD_SIG_LOW) || (signatureOutcome == `PCD_SIG_VALID) ||
                        (signatureOutcome == `PCD_SIG_HIGH);
  wire pcd_nibble_type sigMapped = sigKnown ? signatureOutcome : `PCD_SIG_UNKNOWN;
  wire pcd_byte_type next_status = channelOff  ? `PCD_STATUS_RESET :
                                   resultValid ? {tierMapped, sigMapped} : status;
  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  // reset to zero
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      status <= `PCD_STATUS_RESET;
    end else begin
      status <= next_status;
    end
  end

  off_clears_a: assert property (@(posedge clk) disable iff (!rstN) channelOff |=> status == 8'h00)
    else $error("status not cleared by channel off");
  rsvd_class_a: assert property (@(posedge clk) disable iff (!rstN)
    (resultValid && !channelOff && requestedPowerTier == 4'h5) |=> status[7:4] == 4'h6)
    else $error("reserved class not reported as class 0");
  sig_known_a: assert property (@(posedge clk) disable iff (!rstN)
    status[3:0] inside {4'h0, 4'h1, 4'h3, 4'h4, 4'h5})
    else $error("reserved signature code reported");
endmodule // pcd_channel_status

/* tb/pcd_host_model.sv */
// Host model issuing command-code reads and writes
`timescale 1ns/1ns
module pcd_host_model
  import pcd_pkg::*;
(
  input  wire logic         clk,
  input  wire pcd_byte_type readData,
  input  wire logic         readHit,
  output pcd_byte_type      cmdCode,
  output pcd_byte_type      cmdWriteData,
  output logic              cmdRead,
  output logic              cmdWrite
);
  initial begin
    cmdRead = 1'b0;
    cmdWrite = 1'b0;
    cmdCode = 8'h00;
    cmdWriteData = 8'h00;
  end
  // One command held for one edge, then strobes dropped and code/data lines inverted
  task automatic xfer(input logic wr, input pcd_byte_type code, input pcd_byte_type wdata,
                      output pcd_byte_type data, output logic hit);
    @(negedge clk);
    cmdRead = !wr;
    cmdWrite = wr;
    cmdCode = code;
    cmdWriteData = wdata;
    @(negedge clk);
    data = readData;
    hit = readHit;
    cmdRead = 1'b0;
    cmdWrite = 1'b0;
    cmdCode = ~code;
    cmdWriteData = ~wdata;
  endtask
endmodule // pcd_host_model

/* tb/pcd_discovery_status_tb_top.sv */
// Testbench for the channel discovery status bank
`timescale 1ns/1ns
`include "pcd_consts.svh"
module pcd_discovery_status_tb_top
  import pcd_pkg::*;
;
  logic           core_clk = 1'b0;
  logic           nrst = 1'b0;
  logic [2:0]     resultValid = 3'h0;
  logic [2:0]     channelOff = 3'h0;
  pcd_nibble_type tier [3];
  pcd_nibble_type sig [3];
  pcd_byte_type   readData, cmdCode, cmdWriteData, rd;
  logic           readHit, cmdRead, cmdWrite, hit;
  logic [15:0]    lfsr = 16'hbcf9;
  int             model [3];
  int             failures = 0;
  int             cmp_count = 0;

  always #25 core_clk = ~core_clk;

  pcd_discovery_status u_dut (.core_clk(core_clk), .nrst(nrst), .resultValid(resultValid),
    .requestedPowerTier2(tier[0]), .requestedPowerTier3(tier[1]), .requestedPowerTier4(tier[2]),
    .signatureOutcome2(sig[0]), .signatureOutcome3(sig[1]), .signatureOutcome4(sig[2]),
    .channelOff(channelOff), .cmdRead(cmdRead), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
    .cmdWriteData(cmdWriteData), .readData(readData), .readHit(readHit));
  pcd_host_model u_host (.clk(core_clk), .readData(readData), .readHit(readHit), .cmdCode(cmdCode),
    .cmdWriteData(cmdWriteData), .cmdRead(cmdRead), .cmdWrite(cmdWrite));

  function automatic logic [15:0] nextRand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Reserved tier reads as class 0, reserved signatures as unknown
  function automatic int expectByte(input logic [3:0] t, input logic [3:0] s);
    logic [3:0] et;
    logic [3:0] es;
    et = (t == `PCD_TIER_RSVD) ? `PCD_TIER_CLASS0 : t;
    es = (s == 4'h2 || s > 4'h5) ? `PCD_SIG_UNKNOWN : s;
    return {et, es};
  endfunction
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic readChan(input pcd_byte_type code, input logic [7:0] exp, input logic expHit);
    u_host.xfer(1'b0, code, 8'h00, rd, hit);
    check("readData", exp, rd);
    check("readHit", {7'h0, expHit}, {7'h0, hit});
  endtask
  task automatic readAll();
    for (int c = 0; c < 3; c++) readChan(8'h0d + c[7:0], model[c][7:0], 1'b1);
  endtask
  // Switch-off wins over a result in the same cycle
  task automatic apply(input logic [2:0] v, input logic [2:0] off, input logic [3:0] t, input logic [3:0] s);
    @(negedge core_clk);
    resultValid = v;
    channelOff = off;
    for (int c = 0; c < 3; c++) begin
      tier[c] = t + c[3:0];
      sig[c] = s + c[3:0];
      if (off[c]) model[c] = 0;
      else if (v[c]) model[c] = expectByte(tier[c], sig[c]);
    end
    @(negedge core_clk);
    resultValid = 3'h0;
    channelOff = 3'h0;
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    for (int c = 0; c < 3; c++) begin
      tier[c] = 4'h0;
      sig[c] = 4'h0;
      model[c] = 0;
    end
    repeat (16) @(negedge core_clk);
    nrst = 1'b1;
    repeat (3) @(negedge core_clk);
    readAll();
    readChan(8'h0c, 8'h00, 1'b0);
    readChan(8'h10, 8'h00, 1'b0);
    for (int i = 0; i < 16; i++) begin
      apply(3'h7, 3'h0, i[3:0], i[3:0]);
      readAll();
    end
    apply(3'h2, 3'h0, 4'h0, 4'h3);
    readAll();
    nrst = 1'b0;
    for (int c = 0; c < 3; c++) model[c] = 0;
    repeat (4) @(negedge core_clk);
    nrst = 1'b1;
    repeat (3) @(negedge core_clk);
    readAll();
    for (int c = 0; c < 3; c++) u_host.xfer(1'b1, 8'h0d + c[7:0], lfsr[7:0], rd, hit);
    readAll();
    for (int n = 0; n < 300; n++) begin
      lfsr = nextRand(lfsr);
      apply(lfsr[2:0], lfsr[5:3] & lfsr[8:6], lfsr[12:9], lfsr[15:12]);
      readAll();
    end
    stop_test();
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    failures++;
    stop_test();
  end
endmodule // pcd_discovery_status_tb_top
